/* File: difd_pkg.sv */
`default_nettype none
package difd_pkg;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned STEP_MIN_MS = 14;
  // Least time in clock cycles; cycles per ms from integer division, rounded down
  localparam int unsigned STEP_MIN_CYC = (STEP_MIN_MS * (CLK_HZ / 1000));

  // ----------------------------------------
  // Widths and reset values
  // ----------------------------------------
  localparam int unsigned REF_W = 16;
  localparam logic [15:0] HOLD_REF_RST = 16'h0000;
  localparam logic [15:0] HOLD_FREQ_RST = 16'h0000;
  // One step is 0.1 % of reference or 0.1 Hz of frequency in these units
  localparam logic [15:0] REF_STEP = 16'h0001;
  localparam logic [15:0] FREQ_STEP = 16'h0001;

  // ----------------------------------------
  // Analog input function codes
  // ----------------------------------------
  typedef enum logic [1:0] {
    AIN_NONE = 2'b00,
    AIN_REFERENCE = 2'b01,
    AIN_FEEDBACK = 2'b10
  } difd_ain_fn_t;
  localparam logic [1:0] VOLT_FN_RST = 2'h1;
  localparam logic [1:0] CURR_FN_RST = 2'h0;
  localparam logic [1:0] REF_FN_EXT_PRESET = 2'h2;

  // ----------------------------------------
  // Grouped signals
  // ----------------------------------------
  typedef struct packed {
    logic freeze_ref;
    logic freeze_out;
    logic speed_up;
    logic speed_down;
    logic catch_up;
    logic slow_down;
    logic ramp_sel;
    logic preset_lsb;
    logic preset_msb;
    logic preset_on;
    logic accurate_stop_n;
    logic setup_lsb;
    logic setup_msb;
    logic reset_start;
    logic coast_n;
    logic quick_stop_n;
    logic dc_brake_n;
    logic stop_n;
  } difd_din_t;

  typedef struct packed {
    logic stop_req;
    logic coast;
    logic quick_stop;
    logic dc_brake;
    logic ramp2;
    logic [1:0] setup;
    logic alarm_clear;
    logic start_req;
  } difd_act_t;

endpackage : difd_pkg
`default_nettype wire

/* File: difd_step_filter.sv */
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// Step pulse qualifier
// ----------------------------------------
// A pulse counts once its high phase and the following low gap both
// lasted the minimum time; shorter glitches are swallowed.
module difd_step_filter #(
  parameter int unsigned MIN_CYC = difd_pkg::STEP_MIN_CYC
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // Raw level and qualified pulse
  input wire logic level_i,
  output logic pulse_o
);
  localparam int unsigned CW = $clog2(MIN_CYC + 1);
  localparam logic [CW-1:0] CNT_MAX = CW'(MIN_CYC);

  logic [CW-1:0] cnt_q;
  logic level_q;
  logic armed_q;
  logic high_ok_q;
  logic pulse_q;

  wire changed = level_i != level_q;
  wire full = cnt_q == CNT_MAX;

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      cnt_q <= '0;
      level_q <= 1'b0;
      armed_q <= 1'b1;
      high_ok_q <= 1'b0;
      pulse_q <= 1'b0;
    end
    else
    begin
      level_q <= level_i;
      pulse_q <= 1'b0;
      if (changed)
      begin
        cnt_q <= '0;
        // A fall keeps the step only if the high phase was long enough;
        // a rise starts it only if the gap before it ran out
        if (!level_i)
          high_ok_q <= full && high_ok_q;
        else
        begin
          high_ok_q <= armed_q;
          armed_q <= 1'b0;
        end
      end
      else if (!full)
        cnt_q <= cnt_q + CW'(1);
      else if (!level_q && !armed_q)
      begin
        // Gap long enough: release the step and rearm
        armed_q <= 1'b1;
        pulse_q <= high_ok_q;
        high_ok_q <= 1'b0;
      end
    end
  end

  assign pulse_o = pulse_q;

endmodule : difd_step_filter
`default_nettype wire

/* File: difd_decoder.sv */
`timescale 1ns/10ps
`default_nettype none
// Function
// - Output hold keeps frequency; only step inputs change it
// - During output hold ignore ordinary stop; coast, quick stop, braking still act
// - Step inputs work only when a reference or output hold is set
// - Step pulse high and low at least 14 ms; one unit per pulse
// - Stepped frequency changes use ramp set two
// - Both low no change; up alone raises; down always lowers
// - Held reference adjustable while stopped, kept across mains loss
// - Offset: none, add percentage, or subtract whenever reduce is high
// - Ramp select zero picks ramp one, one picks ramp two
// - Preset select bits form binary index of four presets
// - With external/preset mode, preset enable picks preset over remote
// - Accurate stop low ramps motor to standstill on selected ramp
// - Delayed speed change waits for chosen sensor edge and timer expiry
// - Pulse reference maps 0 Hz to minimum, max frequency to maximum
// - Pulse count mode stops accurately when counter value reached
// - Setup select bits pick one of four setups under multi-setup
// - Reset-and-start clears alarm then ramps up to preset
// - Encoder modes decode quadrature tracks A and B with direction
// - Voltage input: none, reference (default) or feedback; none ignores it
// - Current input uses same choices, default none
// - Several reference sources sum into effective reference
// - Signal below half minimum scaling too long triggers time-out action
module difd_decoder #(
  parameter int unsigned REF_W = difd_pkg::REF_W,
  parameter int unsigned STEP_CYC = difd_pkg::STEP_MIN_CYC,
  parameter int unsigned TMO_W = 32
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // Digital input functions
  input wire difd_pkg::difd_din_t din_i,
  // Configuration
  input wire logic multi_setup_i,
  input wire logic [1:0] ref_function_i,
  input wire logic [1:0] voltage_input_function_i,
  input wire logic voltage_fn_valid_i,
  input wire logic [1:0] current_input_function_i,
  input wire logic current_fn_valid_i,
  input wire logic [REF_W-1:0] offset_pct_i,
  input wire logic [4*REF_W-1:0] preset_refs_i,
  input wire logic [REF_W-1:0] remote_ref_i,
  input wire logic [REF_W-1:0] present_freq_i,
  input wire logic [REF_W-1:0] ref_min_i,
  input wire logic [REF_W-1:0] ref_max_i,
  // Analog inputs, already scaled
  input wire logic [REF_W-1:0] volt_val_i,
  input wire logic [REF_W-1:0] volt_min_scaling_i,
  input wire logic [REF_W-1:0] curr_val_i,
  input wire logic [REF_W-1:0] curr_min_scaling_i,
  input wire logic [TMO_W-1:0] timeout_cyc_i,
  // Pulse and encoder
  input wire logic pulse_ref_mode_i,
  input wire logic [REF_W-1:0] pulse_freq_i,
  input wire logic [REF_W-1:0] pulse_max_i,
  input wire logic count_mode_i,
  input wire logic encoder_mode_i,
  input wire logic pulse_in_i,
  input wire logic enc_a_i,
  input wire logic enc_b_i,
  input wire logic [REF_W-1:0] count_target_i,
  input wire logic count_clear_i,
  // Delayed speed change
  input wire logic delay_en_i,
  input wire logic [15:0] app_ctrl_word_i,
  input wire logic sensor_a_i,
  input wire logic sensor_b_i,
  input wire logic [TMO_W-1:0] delay_cyc_i,
  input wire logic [REF_W-1:0] new_ref_i,
  // Results
  output difd_pkg::difd_act_t act_o,
  output logic [REF_W-1:0] ref_o,
  output logic [REF_W-1:0] hold_freq_o,
  output logic hold_freq_active_o,
  output logic hold_ref_save_o,
  output logic [REF_W-1:0] feedback_o,
  output logic [REF_W-1:0] pulse_ref_o,
  output logic [REF_W-1:0] count_o,
  output logic enc_dir_o,
  output logic timeout_o,
  output logic [REF_W-1:0] delayed_ref_o
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [REF_W-1:0] sat_add(input logic [REF_W-1:0] a, input logic [REF_W-1:0] b);
    logic [REF_W:0] s;
    s = {1'b0, a} + {1'b0, b};
    sat_add = s[REF_W] ? '1 : s[REF_W-1:0];
  endfunction : sat_add

  function automatic logic [REF_W-1:0] sat_sub(input logic [REF_W-1:0] a, input logic [REF_W-1:0] b);
    sat_sub = (a > b) ? a - b : '0;
  endfunction : sat_sub

  // ----------------------------------------
  // Step inputs
  // ----------------------------------------
  logic up_pulse;
  logic down_pulse;

  difd_step_filter #(.MIN_CYC(STEP_CYC)) u_up (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .level_i(din_i.speed_up),
    .pulse_o(up_pulse)
  );

  difd_step_filter #(.MIN_CYC(STEP_CYC)) u_down (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .level_i(din_i.speed_down),
    .pulse_o(down_pulse)
  );

  wire hold_any = din_i.freeze_ref | din_i.freeze_out;
  // Down wins when both are high
  wire step_dn = hold_any & down_pulse;
  wire step_up = hold_any & up_pulse & ~din_i.speed_down;

  // ----------------------------------------
  // Held reference and frequency
  // ----------------------------------------
  logic [REF_W-1:0] hold_ref_q;
  logic [REF_W-1:0] hold_freq_q;
  logic freeze_out_q;
  logic freeze_ref_q;

  // Held reference keeps updating even when stopped; the save strobe tells
  // the drive to write it to non-volatile storage so mains loss keeps it.
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      hold_ref_q <= difd_pkg::HOLD_REF_RST;
      hold_freq_q <= difd_pkg::HOLD_FREQ_RST;
      freeze_out_q <= 1'b0;
      freeze_ref_q <= 1'b0;
    end
    else
    begin
      freeze_out_q <= din_i.freeze_out;
      freeze_ref_q <= din_i.freeze_ref;
      if (din_i.freeze_ref && !freeze_ref_q)
        hold_ref_q <= remote_ref_i;
      else if (din_i.freeze_ref && step_dn)
        hold_ref_q <= sat_sub(hold_ref_q, difd_pkg::REF_STEP);
      else if (din_i.freeze_ref && step_up)
        hold_ref_q <= sat_add(hold_ref_q, difd_pkg::REF_STEP);
      if (din_i.freeze_out && !freeze_out_q)
        hold_freq_q <= present_freq_i;
      else if (din_i.freeze_out && step_dn)
        hold_freq_q <= sat_sub(hold_freq_q, difd_pkg::FREQ_STEP);
      else if (din_i.freeze_out && step_up)
        hold_freq_q <= sat_add(hold_freq_q, difd_pkg::FREQ_STEP);
    end
  end

  assign hold_freq_o = hold_freq_q;
  assign hold_freq_active_o = freeze_out_q;
  assign hold_ref_save_o = freeze_ref_q & (step_up | step_dn);

  // ----------------------------------------
  // Reference forming
  // ----------------------------------------
  wire [1:0] preset_idx = {din_i.preset_msb, din_i.preset_lsb};
  wire [REF_W-1:0] preset_ref = preset_refs_i[preset_idx*REF_W +: REF_W];
  wire use_preset = (ref_function_i == difd_pkg::REF_FN_EXT_PRESET) & din_i.preset_on;
  wire [REF_W-1:0] base_ref = use_preset ? preset_ref : remote_ref_i;

  // Function codes not flagged valid fall back to the defaults
  wire [1:0] vfn = voltage_fn_valid_i ? voltage_input_function_i : difd_pkg::VOLT_FN_RST;
  wire [1:0] cfn = current_fn_valid_i ? current_input_function_i : difd_pkg::CURR_FN_RST;
  wire v_ref = vfn == difd_pkg::AIN_REFERENCE;
  wire c_ref = cfn == difd_pkg::AIN_REFERENCE;
  wire v_fb = vfn == difd_pkg::AIN_FEEDBACK;
  wire c_fb = cfn == difd_pkg::AIN_FEEDBACK;

  // Pulse reference: linear map of 0..pulse_max onto ref_min..ref_max
  logic [2*REF_W-1:0] pulse_prod;
  logic [REF_W-1:0] pulse_span;
  logic [REF_W-1:0] pulse_f;
  always_comb
  begin
    pulse_f = (pulse_freq_i > pulse_max_i) ? pulse_max_i : pulse_freq_i;
    pulse_prod = pulse_f * sat_sub(ref_max_i, ref_min_i);
    pulse_span = (pulse_max_i == '0) ? '0 : REF_W'(pulse_prod / pulse_max_i);
  end
  wire [REF_W-1:0] pulse_ref = sat_add(ref_min_i, pulse_span);

  logic [REF_W-1:0] sum_ref;
  always_comb
  begin
    sum_ref = freeze_ref_q ? hold_ref_q : base_ref;
    if (v_ref)
      sum_ref = sat_add(sum_ref, volt_val_i);
    if (c_ref)
      sum_ref = sat_add(sum_ref, curr_val_i);
    if (pulse_ref_mode_i)
      sum_ref = sat_add(sum_ref, pulse_ref);
  end

  wire [REF_W-1:0] off_ref = din_i.slow_down ? sat_sub(sum_ref, offset_pct_i)
    : (din_i.catch_up ? sat_add(sum_ref, offset_pct_i) : sum_ref);

  logic [REF_W-1:0] ref_q;
  logic [REF_W-1:0] fb_q;
  logic [REF_W-1:0] pref_q;
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      ref_q <= '0;
      fb_q <= '0;
      pref_q <= '0;
    end
    else
    begin
      ref_q <= off_ref;
      fb_q <= sat_add(v_fb ? volt_val_i : '0, c_fb ? curr_val_i : '0);
      pref_q <= pulse_ref;
    end
  end
  assign ref_o = ref_q;
  assign feedback_o = fb_q;
  assign pulse_ref_o = pref_q;

  // ----------------------------------------
  // Encoder and pulse counter
  // ----------------------------------------
  logic [1:0] enc_q;
  logic pulse_q;
  logic dir_q;
  logic [REF_W-1:0] cnt_q;
  logic cnt_stop_q;
  // Gray step detection: a to b leading is forward
  wire enc_step = encoder_mode_i & ((enc_a_i ^ enc_q[1]) ^ (enc_b_i ^ enc_q[0]));
  wire enc_fwd = enc_a_i ^ enc_q[0];
  wire pul_edge = ~encoder_mode_i & pulse_in_i & ~pulse_q;
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      enc_q <= 2'h0;
      pulse_q <= 1'b0;
      dir_q <= 1'b0;
      cnt_q <= '0;
      cnt_stop_q <= 1'b0;
    end
    else
    begin
      enc_q <= {enc_a_i, enc_b_i};
      pulse_q <= pulse_in_i;
      if (enc_step)
        dir_q <= enc_fwd;
      if (count_clear_i)
      begin
        cnt_q <= '0;
        cnt_stop_q <= 1'b0;
      end
      else if (count_mode_i && !cnt_stop_q && (pul_edge || enc_step))
      begin
        cnt_q <= cnt_q + REF_W'(1);
        if (cnt_q + REF_W'(1) >= count_target_i)
          cnt_stop_q <= 1'b1;
      end
    end
  end
  assign count_o = cnt_q;
  assign enc_dir_o = dir_q;

  // ----------------------------------------
  // Live-zero supervision
  // ----------------------------------------
  logic [TMO_W-1:0] tmo_q;
  logic tmo_flag_q;
  wire v_low = (v_ref | v_fb) & (volt_val_i < (volt_min_scaling_i >> 1));
  wire c_low = (c_ref | c_fb) & (curr_val_i < (curr_min_scaling_i >> 1));
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      tmo_q <= '0;
      tmo_flag_q <= 1'b0;
    end
    else if (v_low || c_low)
    begin
      if (tmo_q < timeout_cyc_i)
        tmo_q <= tmo_q + TMO_W'(1);
      else
        tmo_flag_q <= 1'b1;
    end
    else
    begin
      tmo_q <= '0;
      tmo_flag_q <= 1'b0;
    end
  end
  assign timeout_o = tmo_flag_q;

  // ----------------------------------------
  // Delayed speed change
  // ----------------------------------------
  logic sens_q;
  logic wait_q;
  logic timing_q;
  logic [TMO_W-1:0] dly_q;
  logic [REF_W-1:0] dref_q;
  wire sens_sel = app_ctrl_word_i[2] ? sensor_b_i : sensor_a_i;
  wire ref_change = new_ref_i != dref_q;
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      sens_q <= 1'b0;
      wait_q <= 1'b0;
      timing_q <= 1'b0;
      dly_q <= '0;
      dref_q <= '0;
    end
    else
    begin
      sens_q <= sens_sel;
      if (!delay_en_i)
      begin
        dref_q <= new_ref_i;
        wait_q <= 1'b0;
        timing_q <= 1'b0;
      end
      else if (timing_q)
      begin
        if (dly_q >= delay_cyc_i)
        begin
          dref_q <= new_ref_i;
          timing_q <= 1'b0;
        end
        else
          dly_q <= dly_q + TMO_W'(1);
      end
      else if (wait_q && (sens_sel != sens_q))
      begin
        wait_q <= 1'b0;
        timing_q <= 1'b1;
        dly_q <= '0;
      end
      else if (!wait_q && ref_change)
        wait_q <= 1'b1;
    end
  end
  assign delayed_ref_o = dref_q;

  // ----------------------------------------
  // Actions
  // ----------------------------------------
  logic rs_q;
  difd_pkg::difd_act_t act_q;
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      rs_q <= 1'b0;
      act_q <= '0;
    end
    else
    begin
      rs_q <= din_i.reset_start;
      act_q.coast <= ~din_i.coast_n;
      act_q.quick_stop <= ~din_i.quick_stop_n;
      act_q.dc_brake <= ~din_i.dc_brake_n;
      // Ordinary and accurate stop are masked while output is held
      act_q.stop_req <= ~din_i.freeze_out & (~din_i.stop_n | ~din_i.accurate_stop_n | cnt_stop_q);
      // Stepped frequency moves on ramp two; accurate stop uses selected ramp
      act_q.ramp2 <= din_i.ramp_sel | (din_i.freeze_out & hold_any);
      act_q.setup <= multi_setup_i ? {din_i.setup_msb, din_i.setup_lsb} : 2'h0;
      act_q.alarm_clear <= din_i.reset_start & ~rs_q;
      act_q.start_req <= rs_q;
    end
  end
  assign act_o = act_q;

endmodule : difd_decoder
`default_nettype wire

/* File: difd_field_model.sv */
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// Quadrature encoder on the motor shaft
// ----------------------------------------
// Tracks hold still while the shaft stands, as a real encoder does
module difd_field_model (
  // Clock and shaft motion
  input wire logic clk_i,
  input wire logic run_i,
  input wire logic fwd_i,
  // Encoder tracks
  output logic enc_a_o,
  output logic enc_b_o
);
  logic [3:0] div_q = 4'h0;
  logic [1:0] ph_q = 2'h0;
  always @(negedge clk_i)
  begin
    div_q <= div_q + 4'h1;
    if (run_i && div_q == 4'h0)
      ph_q <= fwd_i ? ph_q + 2'h1 : ph_q - 2'h1;
  end
  assign enc_a_o = ph_q[1];
  assign enc_b_o = ph_q[1] ^ ph_q[0];
endmodule : difd_field_model
`default_nettype wire

/* File: difd_monitor.sv */
`timescale 1ns/10ps
`default_nettype none
module difd_monitor #(
  parameter int unsigned STEP_CYC = 20
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // Watched ports
  input wire difd_pkg::difd_din_t din_i,
  input wire logic multi_setup_i,
  input wire logic count_mode_i,
  input wire difd_pkg::difd_act_t act_o,
  input wire logic [15:0] hold_freq_o,
  input wire logic hold_freq_active_o,
  input wire logic hold_ref_save_o
);
  // Low-time counters saturate so a long idle never wraps into a false gap
  logic [15:0] up_lo_q, dn_lo_q, up_lo_d, dn_lo_d;
  assign up_lo_d = din_i.speed_up ? 16'h0000 : up_lo_q + {15'h0000, ~&up_lo_q};
  assign dn_lo_d = din_i.speed_down ? 16'h0000 : dn_lo_q + {15'h0000, ~&dn_lo_q};
  always_ff @(posedge clk_i)
  begin
    up_lo_q <= sys_rst_i ? 16'h0000 : up_lo_d;
    dn_lo_q <= sys_rst_i ? 16'h0000 : dn_lo_d;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  a_ramp_sel_follow: assert property (!$past(sys_rst_i) && !$past(din_i.freeze_out) |->
    act_o.ramp2 == $past(din_i.ramp_sel)) else $error("ramp select not followed");
  a_setup_index: assert property (!$past(sys_rst_i) && $past(multi_setup_i) |->
    act_o.setup == {$past(din_i.setup_msb), $past(din_i.setup_lsb)}) else $error("setup index wrong");
  a_coast_pass: assert property (!$past(sys_rst_i) && !$past(din_i.coast_n) |-> act_o.coast)
    else $error("coast not passed");
  a_stop_masked: assert property (!$past(sys_rst_i) && $past(din_i.freeze_out) && !$past(count_mode_i)
    && $past(din_i.coast_n) && $past(din_i.quick_stop_n) && $past(din_i.dc_brake_n) |-> !act_o.stop_req)
    else $error("stop taken during output hold");
  a_accurate_stop: assert property (!$past(sys_rst_i) && !$past(din_i.freeze_out)
    && !$past(din_i.accurate_stop_n) |-> act_o.stop_req) else $error("accurate stop ignored");
  a_alarm_clear: assert property (!$past(sys_rst_i) && $rose(din_i.reset_start) |=> act_o.alarm_clear)
    else $error("alarm clear missing");
  a_clear_once: assert property (act_o.alarm_clear |=> !act_o.alarm_clear)
    else $error("alarm clear too long");
  a_step_gated: assert property (!din_i.freeze_ref && !din_i.freeze_out |-> !hold_ref_save_o)
    else $error("step without hold");
  a_gap_first: assert property (hold_ref_save_o |-> up_lo_q >= STEP_CYC - 1 || dn_lo_q >= STEP_CYC - 1)
    else $error("step before gap");
  a_freq_unit: assert property ($past(hold_freq_active_o) && hold_freq_active_o |->
    hold_freq_o == $past(hold_freq_o) || hold_freq_o == $past(hold_freq_o) + 16'h0001
    || hold_freq_o == $past(hold_freq_o) - 16'h0001) else $error("held frequency jumped");
endmodule : difd_monitor
bind difd_decoder difd_monitor #(.STEP_CYC(STEP_CYC)) i_mon (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
  .din_i(din_i), .multi_setup_i(multi_setup_i), .count_mode_i(count_mode_i), .act_o(act_o),
  .hold_freq_o(hold_freq_o), .hold_freq_active_o(hold_freq_active_o), .hold_ref_save_o(hold_ref_save_o));
`default_nettype wire

/* File: tb.sv */
`timescale 1ns/10ps
`default_nettype none
module tb;
  localparam int unsigned STEP = 20;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  difd_pkg::difd_din_t din;
  difd_pkg::difd_act_t act;
  logic msu, vok, cok, prm, cm, em, pls, clr, den, sa, sb, run, fwd, ea, eb, hfa, hsv, edir, tmo;
  logic [1:0] rfn, vfn, cfn;
  logic [15:0] ofs, rem, pf, rmin, rmax, vv, vmin, cv, pfq, pmax, tgt, nref, refv, hf, fb, pref, cnt, dref, h, acw;
  logic [63:0] pre;
  logic [31:0] tc, dc, r;
  int error_cnt = 0;
  int checked = 0;
  int cyc = 0;
  int saves = 0;
  always #5 clk_i = ~clk_i;
  // Save strobe stands one cycle, so each one is seen at exactly one falling edge
  always @(negedge clk_i)
  begin
    if (hsv === 1'b1)
      saves++;
  end
  difd_field_model i_enc (.clk_i(clk_i), .run_i(run), .fwd_i(fwd), .enc_a_o(ea), .enc_b_o(eb));
  difd_decoder #(.STEP_CYC(STEP)) i_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .din_i(din),
    .multi_setup_i(msu), .ref_function_i(rfn), .voltage_input_function_i(vfn), .voltage_fn_valid_i(vok),
    .current_input_function_i(cfn), .current_fn_valid_i(cok), .offset_pct_i(ofs), .preset_refs_i(pre),
    .remote_ref_i(rem), .present_freq_i(pf), .ref_min_i(rmin), .ref_max_i(rmax), .volt_val_i(vv),
    .volt_min_scaling_i(vmin), .curr_val_i(cv), .curr_min_scaling_i(vmin), .timeout_cyc_i(tc),
    .pulse_ref_mode_i(prm), .pulse_freq_i(pfq), .pulse_max_i(pmax), .count_mode_i(cm), .encoder_mode_i(em),
    .pulse_in_i(pls), .enc_a_i(ea), .enc_b_i(eb), .count_target_i(tgt), .count_clear_i(clr),
    .delay_en_i(den), .app_ctrl_word_i(acw), .sensor_a_i(sa), .sensor_b_i(sb), .delay_cyc_i(dc),
    .new_ref_i(nref), .act_o(act), .ref_o(refv), .hold_freq_o(hf), .hold_freq_active_o(hfa),
    .hold_ref_save_o(hsv), .feedback_o(fb), .pulse_ref_o(pref), .count_o(cnt), .enc_dir_o(edir),
    .timeout_o(tmo), .delayed_ref_o(dref));
  task automatic results;
    $display("errors %0d checks %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : results
  // Hang guard well above the length of the sequence
  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      error_cnt++;
      results();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
    checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("wrong value at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(negedge clk_i);
  endtask : tick
  task automatic step(input logic up, input logic dn, input int hi);
    din.speed_up = up;
    din.speed_down = dn;
    tick(hi);
    din.speed_up = 1'b0;
    din.speed_down = 1'b0;
    tick(STEP + 4);
  endtask : step
  // Down wins when both are high; the held value saturates at zero
  function automatic logic [15:0] hold_next(input logic [15:0] v, input logic up, input logic dn);
    return dn ? (v == 16'h0000 ? v : v - 16'h0001) : (up ? v + 16'h0001 : v);
  endfunction : hold_next
  initial
  begin
    din = '0;
    {din.coast_n, din.quick_stop_n, din.dc_brake_n, din.stop_n, din.accurate_stop_n} = 5'h1f;
    {msu, prm, cm, em, pls, clr, den, sa, sb, run, fwd} = '0;
    {vok, cok, rfn, vfn, cfn} = {2'h3, 2'h2, 4'h0};
    void'($urandom(32'ha57d));
    pre = {$urandom, $urandom} & 64'h0fff0fff0fff0fff;
    rem = $urandom & 16'h0fff;
    {ofs, pf, rmin, rmax, vv, vmin, cv, pfq, pmax, tgt, nref, tc, dc, acw} = '0;
    tick(4);
    sys_rst_i = 1'b0;
    chk({7'h00, act}, 16'h0000, "reset");
    msu = 1'b1;
    repeat (100)
    begin
      r = $urandom;
      {din.ramp_sel, din.setup_msb, din.setup_lsb, din.coast_n} = r[3:0];
      tick(1);
      chk({act.ramp2, act.setup, act.coast}, {12'h000, r[3:1], ~r[0]}, "actions");
    end
    din.coast_n = 1'b1;
    din.preset_on = 1'b1;
    for (int k = 0; k < 4; k++)
    begin
      {din.preset_msb, din.preset_lsb} = k[1:0];
      tick(2);
      chk(refv, pre[k*16 +: 16], "preset");
    end
    din.preset_on = 1'b0;
    ofs = 16'h0010;
    tick(2);
    chk(refv, rem, "remote");
    din.catch_up = 1'b1;
    tick(2);
    chk(refv > rem, 1'b1, "catch up");
    din.slow_down = 1'b1;
    tick(2);
    chk(refv < rem, 1'b1, "both offsets");
    {din.catch_up, din.slow_down, ofs, vv, cv} = {2'h0, 16'h0000, 16'h0123, 16'h0045};
    tick(2);
    chk(refv, rem, "analog none");
    vfn = 2'h1;
    tick(2);
    chk(refv, rem + vv, "voltage ref");
    cfn = 2'h1;
    tick(2);
    chk(refv, rem + vv + cv, "sum");
    {vok, cok} = 2'h0;
    tick(2);
    chk(refv, rem + vv, "defaults");
    {vok, cok, vfn, cfn} = {2'h3, 2'h2, 2'h0};
    tick(2);
    chk(fb, vv, "voltage feedback");
    chk(refv, rem, "feedback not ref");
    step(1'b1, 1'b0, STEP + 2);
    chk(refv, rem, "step unheld");
    din.freeze_ref = 1'b1;
    tick(2);
    h = rem;
    for (int k = 0; k < 4; k++)
    begin
      r = $urandom;
      din.stop_n = r[2];
      step(k != 2, k > 0, (k == 1) ? STEP / 2 : STEP + 2 + r[3:0]);
      if (k != 1)
        h = hold_next(h, k != 2, k > 0);
      chk(refv, h, "held step");
    end
    chk(saves, 16'h0003, "save strobes");
    {din.freeze_ref, din.stop_n, pf} = {2'h1, 16'h0200};
    din.freeze_out = 1'b1;
    tick(2);
    chk(hf, pf, "freeze out");
    chk(hfa, 1'b1, "hold active");
    pf = 16'h0300;
    step(1'b1, 1'b0, STEP + 2);
    chk(hf, 16'h0201, "freq step");
    {din.stop_n, din.accurate_stop_n} = 2'h0;
    tick(2);
    chk(act.stop_req, 1'b0, "stop masked");
    {din.quick_stop_n, din.dc_brake_n} = 2'h0;
    tick(2);
    chk({act.quick_stop, act.dc_brake}, 2'h3, "quick stop and brake");
    {din.quick_stop_n, din.dc_brake_n, din.freeze_out, din.stop_n} = 4'hd;
    tick(2);
    chk(act.stop_req, 1'b1, "accurate stop");
    {din.stop_n, din.accurate_stop_n, din.reset_start} = 3'h7;
    tick(1);
    chk(act.alarm_clear, 1'b1, "alarm clear");
    tick(1);
    chk({act.alarm_clear, act.start_req}, 16'h0001, "start");
    {din.reset_start, prm, rmin, rmax, pmax} = {2'h1, 16'h0010, 16'h0800, 16'h1000};
    tick(3);
    chk(pref, rmin, "pulse min");
    pfq = pmax;
    tick(3);
    chk(pref, rmax, "pulse max");
    {cm, tgt} = {1'b1, 16'h0005};
    for (int k = 1; k <= 5; k++)
    begin
      chk(act.stop_req, 1'b0, "early stop");
      pls = 1'b1;
      tick(2);
      pls = 1'b0;
      tick(3);
    end
    chk(cnt, 16'h0005, "count");
    chk(act.stop_req, 1'b1, "count stop");
    {clr, tgt, em, run, fwd} = {17'h1ffff, 3'h7};
    tick(1);
    clr = 1'b0;
    tick(100);
    {h, r[0]} = {cnt, edir};
    fwd = 1'b0;
    tick(100);
    chk({edir, cnt != h}, {~r[0], 1'b1}, "encoder");
    {run, vfn, vmin, vv, tc} = {3'h1, 16'h0100, 16'h0090, 32'd10};
    tick(30);
    chk(tmo, 1'b0, "above half");
    vv = 16'h0070;
    tick(30);
    chk(tmo, 1'b1, "timeout");
    {den, dc, nref} = {1'b1, 32'd5, 16'h0077};
    tick(3);
    chk(dref == nref, 1'b0, "delay wait");
    sa = 1'b1;
    tick(20);
    chk(dref, nref, "delay done");
    // Control word bit 2 hands the wait over to the second sensor
    {acw, nref, sa} = {16'h0004, 16'h0055, 1'b0};
    tick(3);
    chk(dref == nref, 1'b0, "sensor b wait");
    sb = 1'b1;
    tick(20);
    chk(dref, nref, "sensor b done");
    results();
  end
endmodule : tb
`default_nettype wire
